// file: hdl/lmic_ctrl.sv
// interrupt, detection, driver enable and pwm control registers of the led matrix
// Operation
// [RQ1] test finished sets status bit 3
// [RQ2] open circuit found sets status bit 2
// [RQ3] short circuit found sets status bit 1
// [RQ4] scroll frame end sets status bit 0
// [RQ5] unmasked set flag pulls interrupt low
// [RQ6] writing zero clears a status flag
// [RQ7] writing one to status leaves flag
// [RQ8] four mask bits, reset value 0fh
// [RQ9] mask zero passes, mask one blocks
// [RQ10] write-only detect enable bit 0, reset zero
// [RQ11] detection enable also runs the matrix
// [RQ12] host never sets run and detect together
// [RQ13] bit 7 doubles fade-out step delay
// [RQ14] seven driver enables, bits 6..0, reset off
// [RQ15] per-led driver selects at 2dh..74h
// [RQ16] pwm enable bit 6, reset off
// [RQ17] six-bit duty, fraction code over 64
// [RQ18] pwm registers for drivers 2..7 at 1fh..24h; the code also has one for driver 1 at 1eh
// [RQ19] select low bits report open/short while detecting
// [RQ20] pwm enable picks fade or firefly timing
// [RQ21] matrix off while run bit zero; the code keeps it running while detect is set
// [RQ22] flags stay set until host clears
// [RQ23] interrupt released when nothing unmasked pending
`timescale 1ns/1ps
`default_nettype none
module lmic_ctrl
  import lmic_pkg::*;
(
  input  wire logic                   clk_sys_i,        // system clock, 50 mhz
  input  wire logic                   rst_i,            // sync reset, high
  input  wire logic [7:0]             reg_addr_i,       // register address
  input  wire logic [7:0]             reg_wdata_i,      // register write data
  input  wire logic                   reg_wr_i,         // write strobe, one cycle
  input  wire logic                   reg_rd_i,         // read strobe, one cycle
  output logic      [7:0]             reg_rdata_o,      // read data, next cycle
  output logic                        reg_rvalid_o,     // read data valid pulse
  input  wire logic                   matrix_run_i,     // run bit from mode register
  input  wire logic                   test_done_i,      // detection pass finished
  input  wire logic                   det_valid_i,      // per-led detection result
  input  wire logic [7:0]             det_led_i,        // led of that result
  input  wire logic                   det_open_i,       // open circuit found
  input  wire logic                   det_short_i,      // short circuit found
  input  wire logic                   frame_end_i,      // scroll frame done
  input  wire logic [7:0]             scan_led_i,       // led being scanned
  output logic      [2:0]             led_drv_sel_o,    // its driver select
  output logic                        int_n_o,          // interrupt, low active
  output logic                        matrix_active_o,  // matrix running
  output logic                        detect_en_o,      // detection on
  output logic                        fade_out_double_o,// fade-out step x2
  output logic      [NUM_DRIVERS-1:0] fade_mode_o,      // 1 fade timing, 0 firefly
  output logic      [NUM_DRIVERS-1:0] drv_o             // driver gates
);
  // register decode helper, used for pwm and select ranges
  function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction

  // register state
  logic [NUM_FLAGS-1:0]        flags;        // sticky status flags
  logic [NUM_FLAGS-1:0]        mask;         // interrupt masks
  logic                        detect;       // detection enable
  logic [7:0]                  drv_enable;   // fade bit and driver enables
  logic [6:0]                  pwm_ctl [NUM_DRIVERS];  // pwm enable and duty

  // decode and event nets
  logic [NUM_FLAGS-1:0]        set_ev;       // events this cycle
  logic [NUM_FLAGS-1:0]        clr_req;      // host zero writes this cycle
  logic [NUM_FLAGS-1:0]        next_flags;   // flags after this cycle
  logic                        wr_status;    // write to status
  logic                        wr_mask;      // write to mask
  logic                        wr_detect;    // write to detect
  logic                        wr_drv;       // write to driver enable
  logic                        wr_pwm;       // write to a pwm register
  logic                        wr_sel;       // write to select bank
  logic [2:0]                  pwm_idx;      // pwm register index
  logic [6:0]                  sel_idx;      // select register index

  // sub-block links
  logic [7:0]                  sel_rdata;    // select bank read data
  logic [2:0]                  scan_drv;     // select bank scanner data
  logic                        det_ok;       // valid single-fault result
  logic [1:0]                  det_bits;     // {short, open}
  logic [NUM_DRIVERS-1:0]      pwm_en_vec;   // pwm enables gathered
  logic [NUM_DRIVERS*DUTY_W-1:0] duty_vec;   // duties gathered

  // pwm step timing and read mux
  logic [4:0]                  tick_cnt;     // pwm step divider
  logic                        pwm_tick;     // one-cycle step enable
  logic [7:0]                  next_rdata;   // read mux

  // address decode
  assign wr_status = reg_wr_i && reg_addr_i == ADDR_INT_STATUS;
  assign wr_mask   = reg_wr_i && reg_addr_i == ADDR_INT_MASK;
  assign wr_detect = reg_wr_i && reg_addr_i == ADDR_DETECT_EN;
  assign wr_drv    = reg_wr_i && reg_addr_i == ADDR_DRIVER_EN;
  assign wr_pwm    = reg_wr_i && in_range(reg_addr_i, ADDR_PWM_FIRST, ADDR_PWM_LAST);  // RQ18
  assign wr_sel    = reg_wr_i && in_range(reg_addr_i, ADDR_SEL_FIRST, ADDR_SEL_LAST);  // RQ15

  // register indices inside ranges
  assign pwm_idx   = 3'(reg_addr_i - ADDR_PWM_FIRST);
  assign sel_idx   = 7'(reg_addr_i - ADDR_SEL_FIRST);

  // detection result: both bits high is an invalid report and is dropped
  assign det_ok    = det_valid_i && detect && !(det_open_i && det_short_i);  // RQ19
  assign det_bits  = {det_short_i, det_open_i};

  // status events and host clears
  always_comb begin
    set_ev                = '0;
    set_ev[BIT_TEST_DONE] = test_done_i;                // RQ1
    set_ev[BIT_OPEN]      = det_ok && det_open_i;       // RQ2
    set_ev[BIT_SHORT]     = det_ok && det_short_i;      // RQ3
    set_ev[BIT_FRAME_END] = frame_end_i;                // RQ4
    clr_req               = wr_status ? ~reg_wdata_i[NUM_FLAGS-1:0] : '0;  // RQ6 RQ7
    next_flags            = (flags & ~clr_req) | set_ev;  // set wins over clear  RQ22
  end

  // sticky status flags
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) flags <= RST_INT_STATUS[NUM_FLAGS-1:0];
    else       flags <= next_flags;  // RQ6 RQ7 RQ22
  end

  // interrupt masks
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)        mask <= RST_INT_MASK;  // RQ8
    else if (wr_mask) mask <= reg_wdata_i[NUM_FLAGS-1:0];  // RQ8
  end

  // detection enable, write only
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)          detect <= RST_DETECT_EN[BIT_DETECT];  // RQ10
    else if (wr_detect) detect <= reg_wdata_i[BIT_DETECT];    // RQ10
  end

  // driver enables and fade-out option
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)       drv_enable <= RST_DRIVER_EN;  // RQ14
    else if (wr_drv) drv_enable <= reg_wdata_i;    // RQ13 RQ14
  end

  // pwm control registers, bit 7 unused
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_DRIVERS; i++) pwm_ctl[i] <= RST_PWM_CTL;  // RQ16
    end else if (wr_pwm) begin
      pwm_ctl[pwm_idx] <= reg_wdata_i[6:0];  // RQ16 RQ17 RQ18
    end
  end

  // gather pwm fields per driver
  for (genvar g = 0; g < NUM_DRIVERS; g++) begin : g_gather
    assign pwm_en_vec[g]                    = pwm_ctl[g][BIT_PWM_EN];    // RQ16
    assign duty_vec[g*DUTY_W +: DUTY_W]     = pwm_ctl[g][DUTY_W-1:0];    // RQ17
  end

  // pwm step divider, one-cycle enable per base period
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      tick_cnt <= '0;
      pwm_tick <= 1'b0;
    end else if (tick_cnt == PWM_STEP_CYC - 5'h01) begin
      // last cycle of a step: wrap and pulse
      tick_cnt <= '0;
      pwm_tick <= 1'b1;
    end else begin
      // count toward the step end
      tick_cnt <= tick_cnt + 5'h01;
      pwm_tick <= 1'b0;
    end
  end

  // per-led select bank
  lmic_sel_bank u_sel (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .wr_i       (wr_sel),
    .idx_i      (sel_idx),
    .wdata_i    (reg_wdata_i),
    .rdata_o    (sel_rdata),
    .det_set_i  (det_ok),
    .det_led_i  (det_led_i),
    .det_bits_i (det_bits),
    .scan_led_i (scan_led_i),
    .scan_drv_o (scan_drv)
  );

  // pwm channels
  lmic_pwm u_pwm (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .tick_i    (pwm_tick),
    .drv_en_i  (drv_enable[NUM_DRIVERS-1:0]),
    .pwm_en_i  (pwm_en_vec),
    .duty_i    (duty_vec),
    .drv_o     (drv_o)
  );

  // read mux, unmapped and write-only read as zero
  always_comb begin
    // default covers unmapped and write-only
    next_rdata = 8'h00;
    if (reg_addr_i == ADDR_INT_STATUS) begin
      next_rdata = {4'h0, flags};
    end else if (reg_addr_i == ADDR_INT_MASK) begin
      next_rdata = {4'h0, mask};
    end else if (reg_addr_i == ADDR_DRIVER_EN) begin
      next_rdata = drv_enable;
    end else if (in_range(reg_addr_i, ADDR_PWM_FIRST, ADDR_PWM_LAST)) begin
      next_rdata = {1'b0, pwm_ctl[pwm_idx]};
    end else if (in_range(reg_addr_i, ADDR_SEL_FIRST, ADDR_SEL_LAST)) begin
      next_rdata = sel_rdata;  // RQ19
    end
  end

  // read data register
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end else begin
      // one-cycle valid, data held to next read
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) reg_rdata_o <= next_rdata;
    end
  end

  // interrupt pin: low while any unmasked flag is pending
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) int_n_o <= 1'b1;
    else       int_n_o <= ~|(flags & ~mask);  // RQ5 RQ9 RQ23
  end

  // matrix and driver control outputs
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      matrix_active_o   <= 1'b0;
      detect_en_o       <= 1'b0;
      fade_out_double_o <= 1'b0;
      fade_mode_o       <= '0;
      led_drv_sel_o     <= 3'h0;
    end else begin
      // run and detect are never both set by the host  RQ12
      matrix_active_o   <= matrix_run_i | detect;              // RQ11 RQ21
      detect_en_o       <= detect;                             // RQ10
      fade_out_double_o <= drv_enable[BIT_FADE_DOUBLE];        // RQ13
      fade_mode_o       <= pwm_en_vec;                         // RQ20
      led_drv_sel_o     <= scan_drv;                           // RQ15
    end
  end

  // helper for flag hold check
  logic [NUM_FLAGS-1:0] keep;  // flags that must survive this cycle
  assign keep = flags & ~clr_req;

  // flags set by their events
  AST_TEST_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ1
    test_done_i |=> flags[BIT_TEST_DONE])
    else $error("test done did not set flag");

  AST_OPEN_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ2
    (det_valid_i && detect && det_open_i && !det_short_i) |=> flags[BIT_OPEN])
    else $error("open fault did not set flag");

  AST_SHORT_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ3
    (det_valid_i && detect && det_short_i && !det_open_i) |=> flags[BIT_SHORT])
    else $error("short fault did not set flag");

  AST_FRAME_SET: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ4
    frame_end_i |=> flags[BIT_FRAME_END])
    else $error("frame end did not set flag");

  AST_INVALID_DROP: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ19
    (det_valid_i && det_open_i && det_short_i && !flags[BIT_OPEN]) |=> !flags[BIT_OPEN])
    else $error("invalid report set open flag");

  // interrupt level follows pending flags
  AST_INT_LOW: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ5
    (|(flags & ~mask)) |=> !int_n_o)
    else $error("unmasked flag did not pull interrupt low");

  AST_INT_HIGH: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ23
    !(|(flags & ~mask)) |=> int_n_o)
    else $error("interrupt low with nothing pending");

  // host clears, ignored ones and held flags
  AST_CLEAR_ZERO: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ6
    (wr_status && !reg_wdata_i[BIT_FRAME_END] && !frame_end_i) |=> !flags[BIT_FRAME_END])
    else $error("zero write did not clear flag");

  AST_HOLD_FLAGS: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ7
    1'b1 |=> (flags & $past(keep)) == $past(keep))
    else $error("flag lost without zero write");

  // mask reset value and blocking
  AST_MASK_RESET: assert property (@(posedge clk_sys_i)  // RQ8
    rst_i |=> mask == RST_INT_MASK)
    else $error("mask reset value wrong");

  AST_MASK_BLOCK: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ9
    (mask == 4'hf) [*2] |-> int_n_o)
    else $error("masked flags reached interrupt");

  // matrix, detection and driver controls
  AST_DETECT_RUN: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ11
    detect |=> matrix_active_o)
    else $error("detection did not run matrix");

  AST_RUN_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ21
    !(matrix_run_i || detect) |=> !matrix_active_o)
    else $error("matrix ran with run and detect off");

  AST_DETECT_OUT: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ10
    wr_detect |=> ##1 detect_en_o == $past(reg_wdata_i[BIT_DETECT], 2))
    else $error("detect enable write not taken");

  AST_FADE_BIT: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ13
    wr_drv |=> ##1 fade_out_double_o == $past(reg_wdata_i[BIT_FADE_DOUBLE], 2))
    else $error("fade-out option not taken");

  AST_DRV_OFF: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ14
    (drv_enable[NUM_DRIVERS-1:0] == 7'h00) [*2] |-> drv_o == 7'h00)
    else $error("disabled driver gate on");

  // scenarios worth seeing
  COV_INT_FIRE: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    int_n_o ##1 !int_n_o);

  COV_SET_CLEAR_SAME: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    wr_status && |(set_ev & clr_req));

  COV_DETECT_OPEN: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    det_ok && det_open_i);

  COV_INVALID_REPORT: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    det_valid_i && detect && det_open_i && det_short_i);

  COV_PWM_STEP_ON: cover property (@(posedge clk_sys_i) disable iff (rst_i)
    pwm_tick && drv_o[0]);
endmodule
`default_nettype wire

// file: inc/lmic_pkg.sv
// package: register map, field positions, reset values and timing for the led matrix ctrl
package lmic_pkg;
  // register offsets on the internal register port
  localparam logic [7:0] ADDR_INT_STATUS   = 8'h1a;
  localparam logic [7:0] ADDR_INT_MASK     = 8'h1b;
  localparam logic [7:0] ADDR_DETECT_EN    = 8'h1c;
  localparam logic [7:0] ADDR_DRIVER_EN    = 8'h1d;
  localparam logic [7:0] ADDR_PWM_FIRST    = 8'h1e;
  localparam logic [7:0] ADDR_PWM_LAST     = 8'h24;
  localparam logic [7:0] ADDR_SEL_FIRST    = 8'h2d;
  localparam logic [7:0] ADDR_SEL_LAST     = 8'h74;
  // status and mask bit positions
  localparam int         BIT_TEST_DONE     = 3;
  localparam int         BIT_OPEN          = 2;
  localparam int         BIT_SHORT         = 1;
  localparam int         BIT_FRAME_END     = 0;
  localparam int         NUM_FLAGS         = 4;
  // detect, driver enable and pwm control fields
  localparam int         BIT_DETECT        = 0;
  localparam int         BIT_FADE_DOUBLE   = 7;
  localparam int         BIT_PWM_EN        = 6;
  localparam int         DUTY_W            = 6;
  localparam int         NUM_DRIVERS       = 7;
  localparam int         NUM_SEL_REGS      = 72;
  localparam int         NUM_LEDS          = 144;
  // per-led select field: status bits while detection is on
  localparam int         SEL_W             = 3;
  localparam int         SEL_OPEN_BIT      = 0;
  localparam int         SEL_SHORT_BIT     = 1;
  // reset values
  localparam logic [7:0] RST_INT_STATUS    = 8'h00;
  localparam logic [3:0] RST_INT_MASK      = 4'hf;
  localparam logic [7:0] RST_DETECT_EN     = 8'h00;
  localparam logic [7:0] RST_DRIVER_EN     = 8'h00;
  localparam logic [6:0] RST_PWM_CTL       = 7'h00;
  localparam logic [7:0] RST_SEL           = 8'h00;
  // pwm step time: base period in picoseconds, rounded down to cycles
  localparam int         CLK_PERIOD_PS     = 20000;
  localparam int         PWM_STEP_PS       = 416670;
  localparam int         PWM_STEP_CYC_INT  = (PWM_STEP_PS / CLK_PERIOD_PS < 1) ? 1 :
                                             PWM_STEP_PS / CLK_PERIOD_PS;
  localparam logic [4:0] PWM_STEP_CYC      = 5'(PWM_STEP_CYC_INT);
endpackage

// file: hdl/lmic_sel_bank.sv
// per-led driver select bank with open/short status write-back
`timescale 1ns/1ps
`default_nettype none
module lmic_sel_bank
  import lmic_pkg::*;
(
  input  wire logic       clk_sys_i,   // system clock
  input  wire logic       rst_i,       // sync reset, high
  input  wire logic       wr_i,        // host write strobe
  input  wire logic [6:0] idx_i,       // register index 0..71
  input  wire logic [7:0] wdata_i,     // host write data
  output logic      [7:0] rdata_o,     // register read data
  input  wire logic       det_set_i,   // detection result strobe
  input  wire logic [7:0] det_led_i,   // led number 0..143
  input  wire logic [1:0] det_bits_i,  // {short, open}
  input  wire logic [7:0] scan_led_i,  // led looked up by scanner
  output logic      [2:0] scan_drv_o   // its driver select field
);
  logic [7:0] sel_mem [NUM_SEL_REGS];  // two 3-bit fields per byte
  logic [6:0] det_idx;                 // byte holding detected led
  logic [6:0] scan_idx;                // byte holding scanned led

  assign det_idx  = det_led_i[7:1];
  assign scan_idx = scan_led_i[7:1];

  // host writes, then detection status overwrites the two low bits of its field
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_SEL_REGS; i++) sel_mem[i] <= RST_SEL;
    end else begin
      if (wr_i && idx_i < 7'(NUM_SEL_REGS)) sel_mem[idx_i] <= wdata_i;
      if (det_set_i && det_led_i < 8'(NUM_LEDS)) begin
        if (det_led_i[0]) sel_mem[det_idx][5:4] <= det_bits_i;  // RQ19
        else              sel_mem[det_idx][1:0] <= det_bits_i;  // RQ19
      end
    end
  end

  // read and scanner lookup, out of range reads as zero
  assign rdata_o    = (idx_i < 7'(NUM_SEL_REGS)) ? sel_mem[idx_i] : 8'h00;
  assign scan_drv_o = (scan_led_i >= 8'(NUM_LEDS)) ? 3'h0 :
                      scan_led_i[0] ? sel_mem[scan_idx][6:4] : sel_mem[scan_idx][2:0];  // RQ15
endmodule
`default_nettype wire

// file: hdl/lmic_pwm.sv
// seven pwm channels sharing one 64-step counter
`timescale 1ns/1ps
`default_nettype none
module lmic_pwm
  import lmic_pkg::*;
(
  input  wire logic                        clk_sys_i,  // system clock
  input  wire logic                        rst_i,      // sync reset, high
  input  wire logic                        tick_i,     // one pwm step enable
  input  wire logic [NUM_DRIVERS-1:0]      drv_en_i,   // driver on/off
  input  wire logic [NUM_DRIVERS-1:0]      pwm_en_i,   // pwm mode per driver
  input  wire logic [NUM_DRIVERS*DUTY_W-1:0] duty_i,   // packed duty codes
  output logic      [NUM_DRIVERS-1:0]      drv_o       // driver gate, registered
);
  logic [DUTY_W-1:0] step_cnt;  // position within the 64-step period

  // step counter wraps after 64 steps
  always_ff @(posedge clk_sys_i) begin
    if (rst_i)       step_cnt <= '0;
    else if (tick_i) step_cnt <= step_cnt + 6'h01;
  end

  // each channel: on while count below duty, steady on without pwm
  for (genvar g = 0; g < NUM_DRIVERS; g++) begin : g_ch
    always_ff @(posedge clk_sys_i) begin
      if (rst_i) drv_o[g] <= 1'b0;
      else drv_o[g] <= drv_en_i[g] &&  // RQ14
                       (!pwm_en_i[g] || step_cnt < duty_i[g*DUTY_W +: DUTY_W]);  // RQ17
    end
    AST_ZERO_DUTY: assert property (@(posedge clk_sys_i) disable iff (rst_i)  // RQ17
      (pwm_en_i[g] && duty_i[g*DUTY_W +: DUTY_W] == 6'h00) |=> !drv_o[g])
      else $error("zero duty channel drove on");
  end
endmodule
`default_nettype wire

// file: test/lmic_host_model.sv
// host model: register master standing in for the serial control bus front end
`timescale 1ns/1ps
`default_nettype none
module lmic_host_model
  import lmic_pkg::*;
(
  input  wire logic       clk_sys_i, // system clock
  input  wire logic       run_i,     // matrix run bit held by the host
  input  wire logic [7:0] rdata_i,   // read data from the block
  input  wire logic       rvalid_i,  // read data valid
  output logic      [7:0] addr_o,    // register address
  output logic      [7:0] wdata_o,   // write data
  output logic            wr_o,      // write strobe
  output logic            rd_o       // read strobe
);
  // idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write; lines scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = (a == ADDR_DETECT_EN && run_i) ? 8'h00 : d;
    @(negedge clk_sys_i);
    addr_o = a;
    wdata_o = v;
    wr_o = 1'b1;
    @(negedge clk_sys_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~v;
  endtask
  // one read, answer waited for under a bound
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
    ok = 1'b0;
    d = 8'h00;
    @(negedge clk_sys_i);
    addr_o = a;
    rd_o = 1'b1;
    @(negedge clk_sys_i);
    rd_o = 1'b0;
    addr_o = ~a;
    for (int i = 0; i < 4 && !ok; i++) begin
      if (rvalid_i === 1'b1) begin
        d = rdata_i;
        ok = 1'b1;
      end else begin
        @(negedge clk_sys_i);
      end
    end
  endtask
endmodule
`default_nettype wire

// file: test/test_led_matrix_irq_and_driver_ctrl.sv
// testbench: registers, sticky flags, interrupt masking, detection and pwm duty
`timescale 1ns/1ps
`default_nettype none
module test_led_matrix_irq_and_driver_ctrl;
  import lmic_pkg::*;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, matrix_run_i = 1'b0, test_done_i = 1'b0;
  logic det_valid_i = 1'b0, det_open_i = 1'b0, det_short_i = 1'b0, frame_end_i = 1'b0;
  logic [7:0] det_led_i = 8'h00, scan_led_i = 8'h00, reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic reg_wr_i, reg_rd_i, reg_rvalid_o, int_n_o, matrix_active_o, detect_en_o, fade_out_double_o;
  logic [2:0] led_drv_sel_o;
  logic [NUM_DRIVERS-1:0] fade_mode_o, drv_o, fm;
  logic [31:0] seed = 32'hf09e;
  logic [7:0] v;
  int errors = 0, n_compared = 0, hi;
  initial forever #10 clk_sys_i = ~clk_sys_i;
  lmic_host_model host (.clk_sys_i(clk_sys_i), .run_i(matrix_run_i), .rdata_i(reg_rdata_o),
    .rvalid_i(reg_rvalid_o), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
    .rd_o(reg_rd_i));
  lmic_ctrl dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o), .matrix_run_i(matrix_run_i),
    .test_done_i(test_done_i), .det_valid_i(det_valid_i), .det_led_i(det_led_i),
    .det_open_i(det_open_i), .det_short_i(det_short_i), .frame_end_i(frame_end_i),
    .scan_led_i(scan_led_i), .led_drv_sel_o(led_drv_sel_o), .int_n_o(int_n_o),
    .matrix_active_o(matrix_active_o), .detect_en_o(detect_en_o),
    .fade_out_double_o(fade_out_double_o), .fade_mode_o(fade_mode_o), .drv_o(drv_o));
  // next random value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected high cycles of one pwm period
  function automatic int duty_cycles(input logic [5:0] code);
    return code * 64 * PWM_STEP_CYC_INT / 64;
  endfunction
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // read a register and compare
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    bit ok;
    host.rd(a, d, ok);
    if (!ok) begin
      errors++;
      wrap_up();
    end else begin
      chk(16'(d), 16'(exp));
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // one-cycle event on source i (3 test, 2 open, 1 short, 0 frame, 4 invalid)
  task automatic fire(input int i, input logic [7:0] led);
    @(negedge clk_sys_i);
    test_done_i = (i == 3);
    frame_end_i = (i == 0);
    det_valid_i = (i == 1 || i == 2 || i == 4);
    det_open_i = (i == 2 || i == 4);
    det_short_i = (i == 1 || i == 4);
    det_led_i = led;
    @(negedge clk_sys_i);
    {test_done_i, frame_end_i, det_valid_i, det_open_i, det_short_i} = 5'h00;
    gap(2);
  endtask
  initial begin
    gap(12);
    rst_i = 1'b0;
    // reset values, write-only and unmapped reads
    chk(16'(int_n_o), 16'h1);
    rdchk(ADDR_INT_STATUS, 8'h00);
    rdchk(ADDR_INT_MASK, 8'h0f);
    rdchk(ADDR_DRIVER_EN, 8'h00);
    rdchk(ADDR_PWM_FIRST, 8'h00);
    rdchk(8'h80, 8'h00);
    host.wr(ADDR_DETECT_EN, 8'h01);
    gap(2);
    rdchk(ADDR_DETECT_EN, 8'h00);
    chk(16'({detect_en_o, matrix_active_o}), 16'h3);
    $display("test reset and detect done");
    // each source: masked, unmasked, sticky, one ignored, zero clears
    for (int i = 0; i < NUM_FLAGS; i++) begin
      host.wr(ADDR_INT_MASK, 8'h0f);
      fire(i, 8'(i + 1));
      chk(16'(int_n_o), 16'h1);
      rdchk(ADDR_INT_STATUS, 8'(1 << i));
      host.wr(ADDR_INT_MASK, 8'(4'hf & ~(4'h1 << i)));
      gap(2);
      chk(16'(int_n_o), 16'h0);
      host.wr(ADDR_INT_STATUS, 8'hff);
      rdchk(ADDR_INT_STATUS, 8'(1 << i));
      host.wr(ADDR_INT_STATUS, 8'h00);
      gap(2);
      chk(16'(int_n_o), 16'h1);
    end
    fire(4, 8'h04);
    rdchk(ADDR_INT_STATUS, 8'h00);
    rdchk(8'h2e, 8'h12);
    rdchk(8'h2f, 8'h00);
    host.wr(ADDR_DETECT_EN, 8'h00);
    gap(2);
    chk(16'({detect_en_o, matrix_active_o}), 16'h0);
    matrix_run_i = 1'b1;
    gap(2);
    chk(16'(matrix_active_o), 16'h1);
    host.wr(ADDR_DETECT_EN, 8'h01);
    matrix_run_i = 1'b0;
    $display("test flags and masks done");
    // random register contents, pwm bit 7 reads zero
    for (int a = ADDR_DRIVER_EN; a <= ADDR_PWM_LAST; a++) begin
      seed = lfsr(seed);
      v = seed[7:0];
      host.wr(8'(a), v);
      if (a == ADDR_DRIVER_EN) begin
        gap(2);
        chk(16'(fade_out_double_o), 16'(v[BIT_FADE_DOUBLE]));
        rdchk(8'(a), v);
      end else begin
        fm[a - ADDR_PWM_FIRST] = v[BIT_PWM_EN];
        rdchk(8'(a), v & 8'h7f);
      end
    end
    gap(2);
    chk(16'(fade_mode_o), 16'(fm));
    seed = lfsr(seed);
    host.wr(ADDR_SEL_FIRST, 8'h53);
    host.wr(ADDR_SEL_LAST, seed[7:0] & 8'h77);
    rdchk(ADDR_SEL_LAST, seed[7:0] & 8'h77);
    scan_led_i = 8'h01;
    gap(2);
    chk(16'(led_drv_sel_o), 16'h5);
    $display("test registers done");
    // duty over one full period: zero, random, top code
    for (int k = 0; k < 3; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 8'h00 : (k == 1) ? 8'(seed[5:0]) : 8'h3f;
      host.wr(ADDR_DRIVER_EN, 8'h01);
      host.wr(ADDR_PWM_FIRST, 8'h40 | v);
      gap(4);
      hi = 0;
      repeat (64 * PWM_STEP_CYC_INT) begin
        @(negedge clk_sys_i);
        if (drv_o[0] === 1'b1) hi++;
      end
      chk(16'(hi), 16'(duty_cycles(v[5:0])));
    end
    host.wr(ADDR_DRIVER_EN, 8'h00);
    gap(4);
    chk(16'(drv_o), 16'h0);
    $display("test pwm done");
    wrap_up();
  end
endmodule
`default_nettype wire
